// file: core/pfs_pkg.sv
// constants and types of the program flash self-programmer
package pfs_pkg;
   localparam int ADDR_W   = 4;
   localparam int DATA_W   = 8;
   localparam int PTR_W    = 22;
   localparam int HOLD_N   = 8;
   localparam int TMR_W    = 18;
   localparam int ROW_LSB  = 6;
   localparam int BLK_LSB  = 3;

   localparam logic [ADDR_W-1:0] OFS_PTR_LO = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PTR_HI = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_PTR_UP = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_LATCH  = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_UNLOCK = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_OP     = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;

   localparam int CB_PGM   = 7;
   localparam int CB_CFG   = 6;
   localparam int CB_ERASE = 4;
   localparam int CB_WERR  = 3;
   localparam int CB_WRITE_ENABLE_BIT  = 2;
   localparam int CB_START = 1;
   localparam int SB_DONE  = 0;
   localparam int SB_BUSY  = 1;
   localparam int OB_WRITE = 2;

   localparam logic [1:0] OP_KEEP    = 2'h0;
   localparam logic [1:0] OP_POSTINC = 2'h1;
   localparam logic [1:0] OP_POSTDEC = 2'h2;
   localparam logic [1:0] OP_PREINC  = 2'h3;

   localparam logic [1:0] UNL_NONE = 2'h0;
   localparam logic [1:0] UNL_KEY1 = 2'h1;
   localparam logic [1:0] UNL_OPEN = 2'h2;

   localparam logic [DATA_W-1:0] UNLOCK_KEY1  = 8'h55;
   localparam logic [DATA_W-1:0] UNLOCK_KEY2  = 8'hAA;
   localparam logic [DATA_W-1:0] HOLD_ERASED  = 8'hFF;

   localparam int LONG_WRITE_US  = 2000;
   localparam int CLK_MHZ        = 100;
   localparam int LONG_WRITE_CYC = LONG_WRITE_US * CLK_MHZ;

   typedef logic [TMR_W-1:0] pfs_tmr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_LONG = 3'b100
   } pfs_state_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pfs_bus_t;

   typedef struct packed {
      logic                    rd;
      logic                    erase;
      logic                    prog;
      logic [PTR_W-1:0]        addr;
      logic [HOLD_N*8-1:0]     wdata;
   } pfs_flreq_t;

   typedef struct packed {
      pfs_state_t                    fsm;
      logic [PTR_W-1:0]              ptr;
      logic [DATA_W-1:0]             latch;
      logic                          pgm_sel;
      logic                          cfg_sel;
      logic                          erase_sel;
      logic                          wr_en;
      logic                          start;
      logic [1:0]                    unlock;
      logic                          done;
      logic                          rd_odd;
      logic                          stall;
      pfs_tmr_t                      timer;
      logic [HOLD_N-1:0][DATA_W-1:0] hold;
      logic [DATA_W-1:0]             rdata;
      pfs_flreq_t                    flreq;
   } pfs_core_t;

   typedef struct packed {
      logic err;
      logic busy_mark;
   } pfs_keep_t;

   localparam pfs_core_t CORE_RST = '{
      fsm: ST_IDLE, ptr: '0, latch: '0, pgm_sel: 1'b0, cfg_sel: 1'b0,
      erase_sel: 1'b0, wr_en: 1'b0, start: 1'b0, unlock: UNL_NONE, done: 1'b0,
      rd_odd: 1'b0, stall: 1'b0, timer: '0, hold: {HOLD_N{HOLD_ERASED}},
      rdata: '0, flreq: '0};
endpackage

// file: core/pfs_sync2.sv
// reset synchroniser: asserts at once, releases after two clock edges
`timescale 1ns/1ps
module pfs_sync2 (
   input  wire logic CLK,
   input  wire logic ARST_N,
   output logic      RST_N_OUT
);
   logic [1:0] sync_r;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         sync_r <= 2'h0;
      end else begin
         sync_r <= {sync_r[0], 1'b1};
      end
   end

   assign RST_N_OUT = sync_r[1];
endmodule

// file: core/pfs_top.sv
// program flash self-programmer: table read/write, row erase, block program
//
// Contract
// - table read fetches one byte into latch
// - pointer bit zero picks high or low byte
// - table read may step the pointer
// - erase always clears a whole 64-byte row
// - erase row from pointer bits 21:6
// - long write halts the processor until timer ends
// - long write lasts about 2 ms
// - programming writes 8-byte blocks from holding registers
// - table write only fills a holding register
// - reset during long write sets write error; a power-on reset (POR_N) clears it instead
// - start bit set-only, hardware clears at end
// - completion raises done flag, software clears
// - pointer bits 2:0 pick holding register
// - erase select makes start do row erase
`timescale 1ns/1ps
module pfs_top #(
   parameter int unsigned LONG_CYC = pfs_pkg::LONG_WRITE_CYC
) (
   input  wire logic               MCLK,
   input  wire logic               RESET_N,
   input  wire logic               POR_N,
   input  wire pfs_pkg::pfs_bus_t  BUS,
   output logic [7:0]              RDATA,
   input  wire logic [15:0]        FL_RDATA,
   output pfs_pkg::pfs_flreq_t     FL_REQ,
   output logic                    CPU_STALL,
   output logic                    NVM_DONE_FLAG,
   output logic                    WRITE_ERROR_FLAG
);
   localparam pfs_pkg::pfs_tmr_t LONG_LAST = pfs_pkg::pfs_tmr_t'(LONG_CYC - 1);

   pfs_pkg::pfs_core_t core_r;
   pfs_pkg::pfs_core_t core_nxt;
   pfs_pkg::pfs_keep_t keep_r;
   pfs_pkg::pfs_keep_t keep_nxt;
   logic               sys_rst_n;
   logic               por_rst_n;
   logic               op_go;
   logic               long_go;
   logic               long_end;
   logic               err_clr;
   logic [21:0]        eff_ptr;

   pfs_sync2 u_sys_sync (
      .CLK       (MCLK),
      .ARST_N    (RESET_N & POR_N),
      .RST_N_OUT (sys_rst_n)
   );

   pfs_sync2 u_por_sync (
      .CLK       (MCLK),
      .ARST_N    (POR_N),
      .RST_N_OUT (por_rst_n)
   );

   // step the low 21 bits of the pointer, bit 21 is kept
   function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic dec);
      logic [20:0] low;
      low = dec ? (p[20:0] - 21'h1) : (p[20:0] + 21'h1);
      return {p[21], low};
   endfunction

   // pointer left behind by the access, for each step mode
   function automatic logic [21:0] ptr_after(input logic [21:0] p, input logic [1:0] mode);
      logic [21:0] r;
      unique case (mode)
         pfs_pkg::OP_KEEP:    r = p;
         pfs_pkg::OP_POSTINC: r = ptr_step(p, 1'b0);
         pfs_pkg::OP_POSTDEC: r = ptr_step(p, 1'b1);
         pfs_pkg::OP_PREINC:  r = ptr_step(p, 1'b0);
      endcase
      return r;
   endfunction

   always_comb begin
      core_nxt              = core_r;
      core_nxt.flreq.rd     = 1'b0;
      core_nxt.flreq.erase  = 1'b0;
      core_nxt.flreq.prog   = 1'b0;
      core_nxt.rdata        = 8'h00;
      op_go                 = 1'b0;
      long_go               = 1'b0;
      long_end              = 1'b0;
      err_clr               = 1'b0;
      eff_ptr               = (BUS.wdata[1:0] == pfs_pkg::OP_PREINC) ? ptr_step(core_r.ptr, 1'b0) : core_r.ptr;

      if (BUS.wr) begin
         if (BUS.addr != pfs_pkg::OFS_UNLOCK) begin
            core_nxt.unlock = pfs_pkg::UNL_NONE;
         end
         unique case (BUS.addr)
            pfs_pkg::OFS_PTR_LO: core_nxt.ptr[7:0]   = BUS.wdata;
            pfs_pkg::OFS_PTR_HI: core_nxt.ptr[15:8]  = BUS.wdata;
            pfs_pkg::OFS_PTR_UP: core_nxt.ptr[21:16] = BUS.wdata[5:0];
            pfs_pkg::OFS_LATCH:  core_nxt.latch      = BUS.wdata;
            pfs_pkg::OFS_UNLOCK: begin
               if (BUS.wdata == pfs_pkg::UNLOCK_KEY1) begin
                  core_nxt.unlock = pfs_pkg::UNL_KEY1;
               end else if (BUS.wdata == pfs_pkg::UNLOCK_KEY2 && core_r.unlock == pfs_pkg::UNL_KEY1) begin
                  core_nxt.unlock = pfs_pkg::UNL_OPEN;
               end else begin
                  core_nxt.unlock = pfs_pkg::UNL_NONE;
               end
            end
            pfs_pkg::OFS_CTRL: begin
               core_nxt.pgm_sel   = BUS.wdata[pfs_pkg::CB_PGM];
               core_nxt.cfg_sel   = BUS.wdata[pfs_pkg::CB_CFG];
               core_nxt.erase_sel = BUS.wdata[pfs_pkg::CB_ERASE];
               core_nxt.wr_en     = BUS.wdata[pfs_pkg::CB_WRITE_ENABLE_BIT];
               err_clr            = !BUS.wdata[pfs_pkg::CB_WERR];
               // start only from software writing one, right after the unlock pair
               if (BUS.wdata[pfs_pkg::CB_START] && !core_r.start && core_r.fsm == pfs_pkg::ST_IDLE
                   && core_r.unlock == pfs_pkg::UNL_OPEN
                   && BUS.wdata[pfs_pkg::CB_PGM] && !BUS.wdata[pfs_pkg::CB_CFG]
                   && BUS.wdata[pfs_pkg::CB_WRITE_ENABLE_BIT]) begin
                  long_go = 1'b1;
               end
            end
            pfs_pkg::OFS_STATUS: begin
               if (BUS.wdata[pfs_pkg::SB_DONE]) begin
                  core_nxt.done = 1'b0;
               end
            end
            pfs_pkg::OFS_OP: op_go = (core_r.fsm == pfs_pkg::ST_IDLE);
            default: ;
         endcase
      end

      if (BUS.rd) begin
         unique case (BUS.addr)
            pfs_pkg::OFS_PTR_LO: core_nxt.rdata = core_r.ptr[7:0];
            pfs_pkg::OFS_PTR_HI: core_nxt.rdata = core_r.ptr[15:8];
            pfs_pkg::OFS_PTR_UP: core_nxt.rdata = {2'h0, core_r.ptr[21:16]};
            pfs_pkg::OFS_LATCH:  core_nxt.rdata = core_r.latch;
            pfs_pkg::OFS_CTRL:   core_nxt.rdata = {core_r.pgm_sel, core_r.cfg_sel, 1'b0, core_r.erase_sel,
                                                   keep_r.err, core_r.wr_en, core_r.start, 1'b0};
            pfs_pkg::OFS_STATUS: core_nxt.rdata = {6'h00, core_r.stall, core_r.done};
            default:             core_nxt.rdata = 8'h00;
         endcase
      end

      if (op_go) begin
         core_nxt.ptr = ptr_after(core_r.ptr, BUS.wdata[1:0]);
         if (BUS.wdata[pfs_pkg::OB_WRITE]) begin
            core_nxt.hold[eff_ptr[2:0]] = core_r.latch;
         end else begin
            core_nxt.fsm         = pfs_pkg::ST_READ;
            core_nxt.flreq.rd    = 1'b1;
            core_nxt.flreq.addr  = {eff_ptr[21:1], 1'b0};
            core_nxt.rd_odd      = eff_ptr[0];
         end
      end

      if (long_go) begin
         core_nxt.fsm    = pfs_pkg::ST_LONG;
         core_nxt.start  = 1'b1;
         core_nxt.stall  = 1'b1;
         core_nxt.timer  = '0;
         if (BUS.wdata[pfs_pkg::CB_ERASE]) begin
            core_nxt.flreq.erase = 1'b1;
            core_nxt.flreq.addr  = {core_r.ptr[21:pfs_pkg::ROW_LSB], 6'h00};
         end else begin
            core_nxt.flreq.prog  = 1'b1;
            core_nxt.flreq.addr  = {core_r.ptr[21:pfs_pkg::BLK_LSB], 3'h0};
            core_nxt.flreq.wdata = core_r.hold;
         end
      end

      unique case (core_r.fsm)
         pfs_pkg::ST_IDLE: ;
         pfs_pkg::ST_READ: begin
            core_nxt.latch = core_r.rd_odd ? FL_RDATA[15:8] : FL_RDATA[7:0];
            core_nxt.fsm   = pfs_pkg::ST_IDLE;
         end
         pfs_pkg::ST_LONG: begin
            core_nxt.timer = core_r.timer + pfs_pkg::pfs_tmr_t'(1);
            if (core_r.timer == LONG_LAST) begin
               long_end       = 1'b1;
               core_nxt.fsm   = pfs_pkg::ST_IDLE;
               core_nxt.stall = 1'b0;
               core_nxt.start = 1'b0;
               core_nxt.done  = 1'b1;
               core_nxt.hold  = {pfs_pkg::HOLD_N{pfs_pkg::HOLD_ERASED}};
            end
         end
         default: core_nxt.fsm = pfs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge sys_rst_n) begin
      if (!sys_rst_n) begin
         core_r <= pfs_pkg::CORE_RST;
      end else begin
         core_r <= core_nxt;
      end
   end

   // survives the system reset so a cut-short long write can be reported
   always_comb begin
      keep_nxt = keep_r;
      if (!sys_rst_n) begin
         if (keep_r.busy_mark) begin
            keep_nxt.err = 1'b1;
         end
         keep_nxt.busy_mark = 1'b0;
      end else begin
         if (err_clr) begin
            keep_nxt.err = 1'b0;
         end
         if (long_go) begin
            keep_nxt.busy_mark = 1'b1;
         end else if (long_end) begin
            keep_nxt.busy_mark = 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge por_rst_n) begin
      if (!por_rst_n) begin
         keep_r <= '0;
      end else begin
         keep_r <= keep_nxt;
      end
   end

   assign RDATA            = core_r.rdata;
   assign FL_REQ           = core_r.flreq;
   assign CPU_STALL        = core_r.stall;
   assign NVM_DONE_FLAG    = core_r.done;
   assign WRITE_ERROR_FLAG = keep_r.err;

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!sys_rst_n);

   sequence s_key1;
      BUS.wr && BUS.addr == pfs_pkg::OFS_UNLOCK && BUS.wdata == pfs_pkg::UNLOCK_KEY1;
   endsequence
   sequence s_key2;
      BUS.wr && BUS.addr == pfs_pkg::OFS_UNLOCK && BUS.wdata == pfs_pkg::UNLOCK_KEY2;
   endsequence
   sequence s_start;
      BUS.wr && BUS.addr == pfs_pkg::OFS_CTRL && BUS.wdata[pfs_pkg::CB_START] && BUS.wdata[pfs_pkg::CB_PGM]
      && !BUS.wdata[pfs_pkg::CB_CFG] && BUS.wdata[pfs_pkg::CB_WRITE_ENABLE_BIT] && core_r.fsm == pfs_pkg::ST_IDLE;
   endsequence
   sequence s_pair;
      s_key1 ##1 s_key2;
   endsequence

   a_read_fetch: assert property (op_go && !BUS.wdata[pfs_pkg::OB_WRITE]
      |=> FL_REQ.rd && FL_REQ.addr[0] == 1'b0 ##1 core_r.fsm == pfs_pkg::ST_IDLE)
      else $error("table read did not fetch one word");
   a_byte_pick: assert property (core_r.fsm == pfs_pkg::ST_READ
      |=> core_r.latch == ($past(core_r.rd_odd) ? $past(FL_RDATA[15:8]) : $past(FL_RDATA[7:0])))
      else $error("wrong byte placed in table latch");
   a_ptr_postinc: assert property (op_go && BUS.wdata[1:0] == pfs_pkg::OP_POSTINC
      |=> core_r.ptr[20:0] == $past(core_r.ptr[20:0]) + 21'h1 && core_r.ptr[21] == $past(core_r.ptr[21]))
      else $error("pointer not incremented after access");
   a_erase_row: assert property (FL_REQ.erase |-> FL_REQ.addr[5:0] == 6'h00 && !FL_REQ.prog)
      else $error("erase not aligned to a 64-byte row");
   a_prog_block: assert property (FL_REQ.prog |-> FL_REQ.addr[2:0] == 3'h0
      && FL_REQ.addr[21:3] == core_r.ptr[21:3])
      else $error("program block address wrong");
   a_stall_hold: assert property ($rose(CPU_STALL) |-> CPU_STALL[*8])
      else $error("stall released too early");
   a_stall_time: assert property (long_end |-> core_r.timer == LONG_LAST && CPU_STALL ##1 !CPU_STALL)
      else $error("long write not ended by the timer");
   a_hold_write: assert property (op_go && BUS.wdata[pfs_pkg::OB_WRITE] && BUS.wdata[1:0] == pfs_pkg::OP_KEEP
      |=> core_r.hold[$past(core_r.ptr[2:0])] == $past(core_r.latch) && !FL_REQ.prog && !FL_REQ.erase)
      else $error("table write did not fill the holding register");
   a_start_clear: assert property ($fell(core_r.start) |-> $past(long_end) && core_r.done)
      else $error("start bit cleared without completion");
   a_done_raise: assert property (long_end |=> NVM_DONE_FLAG)
      else $error("done flag not raised on completion");
   a_unlock_seq: assert property (s_key1 ##1 s_key2 ##1 s_start |=> CPU_STALL && core_r.start)
      else $error("unlock pair plus start did not begin a long write");
   a_unlock_gate: assert property (long_go |-> core_r.unlock == pfs_pkg::UNL_OPEN)
      else $error("long write started without unlock");
   a_erase_sel: assert property (long_go && BUS.wdata[pfs_pkg::CB_ERASE] |=> FL_REQ.erase)
      else $error("erase select did not erase");
   a_err_reset: assert property (@(posedge MCLK) disable iff (!por_rst_n)
      !sys_rst_n && keep_r.busy_mark |=> WRITE_ERROR_FLAG)
      else $error("reset during long write not flagged");
   a_read_word: assert property (op_go && !BUS.wdata[pfs_pkg::OB_WRITE]
      && BUS.wdata[1:0] != pfs_pkg::OP_PREINC
      |=> FL_REQ.addr[21:1] == $past(core_r.ptr[21:1]) && core_r.rd_odd == $past(core_r.ptr[0]))
      else $error("table read used the wrong byte");
   a_read_once: assert property (core_r.fsm == pfs_pkg::ST_READ
      |=> core_r.fsm == pfs_pkg::ST_IDLE && !FL_REQ.rd)
      else $error("table read fetched more than once");
   a_ptr_postdec: assert property (op_go && BUS.wdata[1:0] == pfs_pkg::OP_POSTDEC
      |=> core_r.ptr[20:0] == $past(core_r.ptr[20:0]) - 21'h1 && core_r.ptr[21] == $past(core_r.ptr[21]))
      else $error("pointer not decremented after access");
   a_ptr_keep: assert property (op_go && BUS.wdata[1:0] == pfs_pkg::OP_KEEP
      |=> core_r.ptr == $past(core_r.ptr))
      else $error("pointer moved on a plain access");
   a_erase_addr: assert property (long_go && BUS.wdata[pfs_pkg::CB_ERASE]
      |=> FL_REQ.addr[21:6] == $past(core_r.ptr[21:6]))
      else $error("erase row taken from wrong pointer bits");
   a_prog_data: assert property (long_go && !BUS.wdata[pfs_pkg::CB_ERASE]
      |=> FL_REQ.prog && FL_REQ.wdata == $past(core_r.hold))
      else $error("program data not the holding registers");
   a_hold_only: assert property (op_go && BUS.wdata[pfs_pkg::OB_WRITE]
      |=> !FL_REQ.prog && !FL_REQ.erase && !FL_REQ.rd && !CPU_STALL)
      else $error("table write reached the flash array");
   a_no_sw_clear: assert property (core_r.start && BUS.wr && BUS.addr == pfs_pkg::OFS_CTRL
      && !BUS.wdata[pfs_pkg::CB_START] && !long_end |=> core_r.start)
      else $error("software cleared the start bit");
   a_done_clear: assert property (NVM_DONE_FLAG && BUS.wr && BUS.addr == pfs_pkg::OFS_STATUS
      && BUS.wdata[pfs_pkg::SB_DONE] && !long_end |=> !NVM_DONE_FLAG)
      else $error("done flag not cleared by software");
   a_done_hold: assert property (NVM_DONE_FLAG && !(BUS.wr && BUS.addr == pfs_pkg::OFS_STATUS)
      |=> NVM_DONE_FLAG)
      else $error("done flag dropped on its own");
   a_unlock_close: assert property (BUS.wr && BUS.addr != pfs_pkg::OFS_UNLOCK
      |=> core_r.unlock == pfs_pkg::UNL_NONE)
      else $error("unlock stayed open after another write");
   a_unlock_open: assert property (s_pair
      |=> core_r.unlock == pfs_pkg::UNL_OPEN)
      else $error("unlock pair did not open the gate");
   a_err_hold: assert property (@(posedge MCLK) disable iff (!por_rst_n)
      WRITE_ERROR_FLAG && (!sys_rst_n || !err_clr) |=> WRITE_ERROR_FLAG)
      else $error("write error flag lost");
   a_err_clear: assert property (@(posedge MCLK) disable iff (!por_rst_n)
      sys_rst_n && err_clr |=> !WRITE_ERROR_FLAG)
      else $error("write error flag not cleared");
   a_stall_start: assert property (long_go
      |=> CPU_STALL && core_r.timer == '0)
      else $error("long write did not stall the processor");
   a_halt_ops: assert property (CPU_STALL
      |-> !op_go && !long_go)
      else $error("operation accepted during a long write");
   a_stall_busy: assert property (CPU_STALL
      |-> core_r.start && core_r.fsm == pfs_pkg::ST_LONG)
      else $error("stall without a running long write");
endmodule

// file: test/pfs_flash_model.sv
// flash array model: byte store, word reads, row erase, block program
`timescale 1ns/1ps
module pfs_flash_model (
   input  wire logic                clk,
   input  wire pfs_pkg::pfs_flreq_t req,
   output logic [15:0]              rdata
);
   logic [7:0]  mem [int];
   logic [15:0] noise = 16'hA5C3;

   function automatic logic [7:0] rb(int a);
      return mem.exists(a) ? mem[a] : 8'(a * 7 + 3);
   endfunction

   // word answered while the read pulse stands, a moving pattern otherwise
   always_comb rdata = req.rd ? {rb(int'(req.addr) | 1), rb(int'(req.addr) & ~1)} : noise;

   always @(posedge clk) begin
      noise <= {noise[14:0], noise[15] ^ noise[12]};
      if (req.erase)
         for (int i = 0; i < 64; i++)
            mem[int'({req.addr[21:6], 6'h0}) + i] = 8'hFF;
      if (req.prog)
         for (int i = 0; i < 8; i++)
            mem[int'({req.addr[21:3], 3'h0}) + i] = req.wdata[8*i +: 8];
   end
endmodule

// file: test/tb_pfs_top.sv
// self-checking bench of the program flash self-programmer
`timescale 1ns/1ps
module tb_pfs_top;
   localparam int LC = 16;
   localparam logic [7:0] BADC [4] = '{8'h86, 8'h82, 8'hC6, 8'h06};
   logic                MCLK = 1'b0;
   logic                RESET_N = 1'b0;
   logic                POR_N = 1'b0;
   pfs_pkg::pfs_bus_t   BUS = '0;
   logic [7:0]          RDATA;
   logic [15:0]         FL_RDATA;
   pfs_pkg::pfs_flreq_t FL_REQ;
   logic                CPU_STALL;
   logic                NVM_DONE_FLAG;
   logic                WRITE_ERROR_FLAG;
   int                  fail_count = 0;
   int                  comparisons = 0;
   int                  n_stall;
   int                  n_long;
   int                  ptr;
   int                  blk;
   logic [7:0]          lat;
   logic [7:0]          d;
   logic [7:0]          hold [8];
   logic [7:0]          rmem [int];
   logic [21:0]         l_addr;
   logic [63:0]         l_wd;

   pfs_top #(.LONG_CYC(LC)) uut (.MCLK(MCLK), .RESET_N(RESET_N), .POR_N(POR_N), .BUS(BUS),
      .RDATA(RDATA), .FL_RDATA(FL_RDATA), .FL_REQ(FL_REQ), .CPU_STALL(CPU_STALL),
      .NVM_DONE_FLAG(NVM_DONE_FLAG), .WRITE_ERROR_FLAG(WRITE_ERROR_FLAG));
   pfs_flash_model flash (.clk(MCLK), .req(FL_REQ), .rdata(FL_RDATA));

   initial begin
      forever #5 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      if (CPU_STALL === 1'b1)
         n_stall++;
      if (FL_REQ.prog === 1'b1 || FL_REQ.erase === 1'b1) begin
         n_long++;
         l_addr = FL_REQ.addr;
         l_wd = FL_REQ.wdata;
      end
   end

   function automatic int step(int p, int dlt);
      return (p & 32'h200000) | ((p + dlt) & 32'h1FFFFF);
   endfunction

   function automatic logic [7:0] rref(int a);
      return rmem.exists(a) ? rmem[a] : 8'(a * 7 + 3);
   endfunction

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp(string s, logic [63:0] e, logic [63:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [7:0] v);
      @(posedge MCLK);
      BUS <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge MCLK);
      BUS <= '0;
   endtask

   // unlock pair and control write on three back-to-back cycles
   task automatic unl(logic [7:0] k, logic [7:0] c);
      @(posedge MCLK);
      BUS <= '{wr: 1'b1, rd: 1'b0, addr: 4'h5, wdata: pfs_pkg::UNLOCK_KEY1};
      @(posedge MCLK);
      BUS <= '{wr: 1'b1, rd: 1'b0, addr: 4'h5, wdata: k};
      @(posedge MCLK);
      BUS <= '{wr: 1'b1, rd: 1'b0, addr: 4'h4, wdata: c};
      @(posedge MCLK);
      BUS <= '0;
   endtask

   task automatic rd(logic [3:0] a, output logic [7:0] v);
      @(posedge MCLK);
      BUS <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge MCLK);
      BUS <= '0;
      #1 v = RDATA;
   endtask

   task automatic rc(logic [3:0] a, logic [7:0] m, logic [7:0] e, string s);
      rd(a, d);
      cmp(s, e, d & m);
   endtask

   task automatic setp(int p);
      ptr = p;
      wr(4'h0, p[7:0]);
      wr(4'h1, p[15:8]);
      wr(4'h2, p[23:16]);
   endtask

   task automatic chkp();
      logic [7:0] a, b, c;
      rd(4'h0, a);
      rd(4'h1, b);
      rd(4'h2, c);
      cmp("pointer", ptr, {c[5:0], b, a});
      rd(4'h3, a);
      cmp("latch", lat, a);
   endtask

   // one table operation in the design and in the reference
   task automatic top(bit w, logic [1:0] m);
      if (m == pfs_pkg::OP_PREINC) ptr = step(ptr, 1);
      wr(4'h6, {5'h0, w, m});
      repeat (2) @(posedge MCLK);
      if (w) hold[ptr & 7] = lat;
      else lat = rref(ptr);
      if (m == pfs_pkg::OP_POSTINC) ptr = step(ptr, 1);
      if (m == pfs_pkg::OP_POSTDEC) ptr = step(ptr, -1);
   endtask

   // unlock pair, start, a refused clear of start, then wait for the end
   task automatic go(logic [7:0] k, logic [7:0] c, bit ok);
      int n, n0;
      logic [63:0] w;
      n_stall = 0;
      n0 = n_long;
      for (int i = 0; i < 8; i++)
         w[8*i +: 8] = hold[i];
      unl(k, c);
      wr(4'h4, c & 8'hFD);
      rc(4'h4, 8'h02, {6'h0, ok, 1'b0}, "start bit");
      rc(4'h7, 8'h02, {6'h0, ok, 1'b0}, "busy bit");
      n = 0;
      while (CPU_STALL !== 1'b0 && n < 100) begin
         @(posedge MCLK);
         #1 n++;
      end
      if (n == 100) begin
         fail_count++;
         print_verdict();
      end
      cmp("stall cycles", ok ? LC : 0, n_stall);
      cmp("long writes", n0 + ok, n_long);
      cmp("done flag", ok, NVM_DONE_FLAG);
      if (ok) begin
         cmp("long addr", ptr & (c[4] ? 32'h3FFFC0 : 32'h3FFFF8), l_addr);
         if (!c[4]) cmp("block data", w, l_wd);
         for (int i = 0; i < 64; i++)
            if (c[4]) rmem[(ptr & 32'h3FFFC0) + i] = 8'hFF;
            else if (i < 8) rmem[(ptr & 32'h3FFFF8) + i] = hold[i];
         hold = '{default: 8'hFF};
      end
      wr(4'h7, 8'h01);
      rc(4'h7, 8'h01, 8'h00, "done cleared");
   endtask

   initial begin
      d = $urandom(32'h92faa461);
      hold = '{default: 8'hFF};
      ptr = 0;
      lat = 0;
      n_long = 0;
      repeat (20) @(posedge MCLK);
      RESET_N <= 1'b1;
      POR_N <= 1'b1;
      repeat (5) @(posedge MCLK);
      wr(4'h9, 8'hFF);
      for (int a = 0; a < 16; a++)
         rc(4'(a), 8'hFF, 8'h00, "reset value");
      $display("test reset values done");
      for (int j = 0; j < 2; j++) begin
         setp(j ? ($urandom & 32'h3FFFFF) : 32'h3FFFFE);
         for (int i = 0; i < 8; i++) begin
            top(1'b0, 2'(i));
            chkp();
         end
      end
      $display("test table reads done");
      blk = $urandom & 32'h3FFFF8;
      setp((blk & 32'h3FFFC0) | ($urandom & 63));
      go(pfs_pkg::UNLOCK_KEY2, 8'h96, 1'b1);
      setp((blk & 32'h3FFFC0) + 62);
      for (int i = 0; i < 4; i++) begin
         top(1'b0, pfs_pkg::OP_POSTINC);
         chkp();
      end
      $display("test row erase done");
      setp(blk + 2);
      for (int i = 0; i < 8; i++) begin
         lat = 8'($urandom);
         wr(4'h3, lat);
         top(1'b1, 2'(i));
      end
      go(pfs_pkg::UNLOCK_KEY2, 8'h86, 1'b1);
      setp(blk);
      for (int i = 0; i < 8; i++) begin
         top(1'b0, pfs_pkg::OP_POSTINC);
         chkp();
      end
      $display("test block program done");
      for (int i = 0; i < 4; i++)
         go(i ? pfs_pkg::UNLOCK_KEY2 : 8'h5A, BADC[i], 1'b0);
      $display("test refused starts done");
      unl(pfs_pkg::UNLOCK_KEY2, 8'h86);
      repeat (4) @(posedge MCLK);
      RESET_N <= 1'b0;
      repeat (3) @(posedge MCLK);
      RESET_N <= 1'b1;
      repeat (5) @(posedge MCLK);
      ptr = 0;
      lat = 0;
      #1 cmp("write error", 1, WRITE_ERROR_FLAG);
      cmp("stall after reset", 0, CPU_STALL);
      rc(4'h4, 8'h0A, 8'h08, "error bit");
      chkp();
      POR_N <= 1'b0;
      repeat (3) @(posedge MCLK);
      POR_N <= 1'b1;
      repeat (5) @(posedge MCLK);
      #1 cmp("error after power-on", 0, WRITE_ERROR_FLAG);
      $display("test aborted write done");
      print_verdict();
   end
endmodule
